// [hdl/ste_apb_regs.sv]
// apb register file for the trigger engine
`timescale 1ns/1ps
`include "ste_regs.svh"
module ste_apb_regs
    import ste_pkg::*;
(
    // clocking
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // settings and status
    output logic [31:0]      ctrlWord,
    output logic [31:0]      trigWord,
    output logic [31:0]      thrWord1,
    output logic [31:0]      thrWord2,
    output logic [31:0]      timeWord1,
    output logic [31:0]      timeWord2,
    output logic [31:0]      autoWord,
    output logic             armPulse,
    output logic             stopPulse,
    input  wire logic [31:0] statusWord,
    input  wire logic [31:0] countWord
);
    logic [31:0] regs_q [0:6];
    wire  access  = psel && penable && clkEn;
    wire  doWrite = access && pwrite;
    wire  [3:0] idx = paddr[5:2];
    wire  mapped  = (paddr[1:0] == 2'h0) && (paddr[11:6] == 6'h00)
                    && (idx <= 4'h8);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign ctrlWord  = regs_q[0];
    assign trigWord  = regs_q[1];
    assign thrWord1  = regs_q[2];
    assign thrWord2  = regs_q[3];
    assign timeWord1 = regs_q[4];
    assign timeWord2 = regs_q[5];
    assign autoWord  = regs_q[6];
    // arm and stop pulse for one cycle on a control word write; the stored control bits keep their value
    assign armPulse  = doWrite && mapped && paddr == `STE_A_CTRL
                       && pwdata[`STE_CTRL_ARM];
    assign stopPulse = doWrite && mapped && paddr == `STE_A_CTRL
                       && pwdata[`STE_CTRL_STOP];

    genvar i;
    generate
        for (i = 0; i < 7; i++) begin : g_reg
            always_ff @(posedge core_clk) begin
                if (reset)
                    regs_q[i] <= (i == 6) ? `STE_RST_AUTO : `STE_RST_WORD;
                else if (doWrite && mapped && idx == 4'(i))
                    regs_q[i] <= pwdata;
            end
        end
    endgenerate

    wire [31:0] rdMux = (idx == 4'h7) ? statusWord :
                        (idx == 4'h8) ? countWord  :
                        (idx <  4'h7) ? regs_q[idx[2:0]] : `STE_RST_WORD;

    always_ff @(posedge core_clk) begin
        if (reset)
            prdata <= `STE_RST_WORD;
        else if (clkEn && psel && !penable && !pwrite)
            prdata <= mapped ? rdMux : `STE_RST_WORD;
    end
endmodule : ste_apb_regs

// [hdl/ste_pkg.sv]
// types shared by the trigger engine modules
package ste_pkg;
    typedef enum logic [3:0] {
        TRG_EDGE    = 4'h0,
        TRG_ADVEDGE = 4'h1,
        TRG_WINDOW  = 4'h2,
        TRG_PWIDTH  = 4'h3,
        TRG_INTERV  = 4'h4,
        TRG_WINPW   = 4'h5,
        TRG_HDIST   = 4'h6,
        TRG_WDIST   = 4'h7,
        TRG_UNDER   = 4'h8
    } ste_type_t;

    typedef enum logic [1:0] {
        MODE_NONE   = 2'h0,
        MODE_AUTO   = 2'h1,
        MODE_REPEAT = 2'h2,
        MODE_SINGLE = 2'h3
    } ste_mode_t;

    typedef struct packed {
        logic [15:0] thr1;
        logic [15:0] thr2;
        logic [31:0] time1;
        logic [31:0] time2;
        logic [3:0]  ttype;
        logic [1:0]  dir;
        logic [1:0]  cond;
        logic        hyst;
        logic        region;
    } ste_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } ste_smp_t;
endpackage : ste_pkg

// [hdl/ste_regs.svh]
// register map, field positions and timing constants for the trigger engine
// What this block does
// - mode None captures continuously, never waits
// - mode Auto forces capture after timeout
// - mode Repeat captures only after each trigger
// - mode Single halts after first capture
// - only the selected channel is evaluated
// - edge fires on threshold crossing
// - direction picks rising or falling crossing
// - slow time base selects continuous streaming
// - continuous mode still supports edge trigger
// - advanced edge may fire on both edges
// - hysteresis: second threshold arms, main fires
// - window fires on enter, exit or either
// - thresholds are window upper and lower
// - pulse width polarity selectable, uses hysteresis
// - more-than and less-than width conditions
// - in-range and out-of-range width conditions
// - interval times same-polarity crossing gap
// - window pulse width: stay in or out
// - horizontal distortion: stay above or below
// - window distortion: enter and stay inside
// - underthrow: return without reaching second threshold
`ifndef STE_REGS_SVH
`define STE_REGS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define STE_A_CTRL    12'h000
`define STE_A_TRIG    12'h004
`define STE_A_THR1    12'h008
`define STE_A_THR2    12'h00c
`define STE_A_TIME1   12'h010
`define STE_A_TIME2   12'h014
`define STE_A_AUTO    12'h018
`define STE_A_STATUS  12'h01c
`define STE_A_COUNT   12'h020

// ************************************************************
// control fields
// ************************************************************
`define STE_CTRL_ARM   0
`define STE_CTRL_STOP  1
`define STE_CTRL_CONT  2
// trigger word: type [3:0], mode [5:4], chan [7:6], dir [9:8],
// cond [11:10], hyst [12], region [13]
`define STE_TRG_TYPE_LO  0
`define STE_TRG_MODE_LO  4
`define STE_TRG_CHAN_LO  6
`define STE_TRG_DIR_LO   8
`define STE_TRG_COND_LO  10
`define STE_TRG_HYST     12
`define STE_TRG_REGION   13

// ************************************************************
// reset values and unit step constants
// ************************************************************
`define STE_RST_WORD  32'h0000_0000
`define STE_RST_AUTO  32'h0003_d090
`define STE_ONE_CNT   32'h0000_0001
`define STE_ONE_SMP   16'h0001

`endif

// [hdl/ste_trigger_engine.sv]
// trigger engine: capture modes and trigger condition detectors
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ste_regs.svh"
module ste_trigger_engine
    import ste_pkg::*;
(
    // clocking
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // sample stream, four channels
    input  wire logic        smpValid,
    input  wire logic [63:0] smpData,
    // capture side
    input  wire logic        captureDone,
    output logic             trigStrobe,
    output logic             captureEn,
    output logic             forcedTrig,
    output logic             streamMode
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [31:0] ctrlWord;
    logic [31:0] trigWord;
    logic [31:0] thrWord1;
    logic [31:0] thrWord2;
    logic [31:0] timeWord1;
    logic [31:0] timeWord2;
    logic [31:0] autoWord;
    logic        armPulse;
    logic        stopPulse;
    logic [31:0] statusWord;
    logic [31:0] countWord;

    ste_apb_regs u_regs (
        .core_clk   (core_clk),
        .reset      (reset),
        .clkEn      (clkEn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .ctrlWord   (ctrlWord),
        .trigWord   (trigWord),
        .thrWord1   (thrWord1),
        .thrWord2   (thrWord2),
        .timeWord1  (timeWord1),
        .timeWord2  (timeWord2),
        .autoWord   (autoWord),
        .armPulse   (armPulse),
        .stopPulse  (stopPulse),
        .statusWord (statusWord),
        .countWord  (countWord)
    );

    // ************************************************************
    // settings latched at arming
    // ************************************************************
    ste_cfg_t  cfg_q;
    ste_mode_t mode_q;
    logic [1:0] chan_q;
    logic [31:0] autoLim_q;
    logic        cont_q;

    // a capture keeps its settings; new writes wait for the next arm
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_q     <= '0;
            mode_q    <= MODE_NONE;
            chan_q    <= 2'h0;
            autoLim_q <= `STE_RST_AUTO;
            cont_q    <= 1'b0;
        end else if (clkEn && armPulse) begin
            cfg_q.thr1   <= thrWord1[15:0];
            cfg_q.thr2   <= thrWord2[15:0];
            cfg_q.time1  <= timeWord1;
            cfg_q.time2  <= timeWord2;
            cfg_q.ttype  <= trigWord[`STE_TRG_TYPE_LO +: 4];
            cfg_q.dir    <= trigWord[`STE_TRG_DIR_LO +: 2];
            cfg_q.cond   <= trigWord[`STE_TRG_COND_LO +: 2];
            cfg_q.hyst   <= trigWord[`STE_TRG_HYST];
            cfg_q.region <= trigWord[`STE_TRG_REGION];
            mode_q       <= ste_mode_t'(trigWord[`STE_TRG_MODE_LO +: 2]);
            chan_q       <= trigWord[`STE_TRG_CHAN_LO +: 2];
            autoLim_q    <= autoWord;
            cont_q       <= pwdata[`STE_CTRL_CONT];
        end
    end

    // ************************************************************
    // selected channel and comparisons
    // ************************************************************
    ste_smp_t smp;
    logic [15:0] prev_q;
    logic        prevOk_q;
    assign smp.valid = smpValid;
    assign smp.data  = smpData[chan_q*16 +: 16];

    wire signed [15:0] cur  = smp.data;
    wire signed [15:0] prv  = prev_q;
    wire signed [15:0] t1   = cfg_q.thr1;
    wire signed [15:0] t2   = cfg_q.thr2;
    wire signed [15:0] winHi = (t1 > t2) ? t1 : t2;
    wire signed [15:0] winLo = (t1 > t2) ? t2 : t1;

    wire step    = smp.valid && prevOk_q;
    wire riseX   = step && prv <  t1 && cur >= t1;
    wire fallX   = step && prv >= t1 && cur <  t1;
    wire above   = cur >= t1;
    wire curIn   = cur >= winLo && cur <= winHi;
    wire prvIn   = prv >= winLo && prv <= winHi;
    wire enterW  = step && !prvIn && curIn;
    wire exitW   = step && prvIn && !curIn;
    wire crossT2 = (t2 > t1) ? cur >= t2 : cur <= t2;

    // ************************************************************
    // hysteresis arming: second threshold arms, main fires
    // ************************************************************
    logic hArmR_q;
    logic hArmF_q;
    wire  hystOn = cfg_q.hyst;
    wire  hRise  = hystOn ? (riseX && hArmR_q) : riseX;
    wire  hFall  = hystOn ? (fallX && hArmF_q) : fallX;

    always_ff @(posedge core_clk) begin
        if (reset || armPulse) begin
            hArmR_q <= 1'b0;
            hArmF_q <= 1'b0;
        end else if (clkEn && smp.valid) begin
            // below the low threshold arms rising, above arms falling
            if (cur <= winLo)
                hArmR_q <= 1'b1;
            else if (hRise)
                hArmR_q <= 1'b0;
            if (cur >= winHi)
                hArmF_q <= 1'b1;
            else if (hFall)
                hArmF_q <= 1'b0;
        end
    end

    // ************************************************************
    // pulse and interval timing
    // ************************************************************
    wire posPol  = (cfg_q.dir == 2'h0);
    wire pStart  = posPol ? hRise : hFall;
    wire pEnd    = posPol ? hFall : hRise;
    logic inPulse_q;
    logic seenEdge_q;
    logic winMatch;
    logic [31:0] width;
    logic        stateChg;

    wire isPw    = cfg_q.ttype == TRG_PWIDTH;
    wire isIv    = cfg_q.ttype == TRG_INTERV;
    // interval restarts on each same-polarity crossing
    wire ivEdge  = (cfg_q.dir == 2'h0) ? riseX : fallX;
    wire restart = isIv ? ivEdge : (isPw ? pStart : stateChg);

    // region state for the stay-type triggers
    logic regionNow;
    logic regionPrev_q;
    logic stayFired_q;
    always_comb begin
        unique case (cfg_q.ttype)
            TRG_WINPW: regionNow = cfg_q.region ? !curIn : curIn;
            TRG_HDIST: regionNow = (cfg_q.dir == 2'h0) ? above : !above;
            TRG_WDIST: regionNow = curIn;
            default:   regionNow = 1'b0;
        endcase
    end
    assign stateChg = smp.valid && (regionNow != regionPrev_q);

    ste_width_cmp u_width (
        .core_clk (core_clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .smpValid (smp.valid),
        .restart  (restart),
        .stop     (1'b0),
        .cond     (cfg_q.cond),
        .time1    (cfg_q.time1),
        .time2    (cfg_q.time2),
        .width    (width),
        .match    (winMatch)
    );

    // ************************************************************
    // underthrow: first threshold crossed, back without the second
    // ************************************************************
    logic utOut_q;
    logic utHit_q;
    wire  utStart = (t2 > t1) ? riseX : fallX;
    wire  utBack  = (t2 > t1) ? fallX : riseX;

    always_ff @(posedge core_clk) begin
        if (reset || armPulse) begin
            utOut_q <= 1'b0;
            utHit_q <= 1'b0;
        end else if (clkEn && smp.valid) begin
            if (utStart) begin
                utOut_q <= 1'b1;
                utHit_q <= 1'b0;
            end else if (utBack)
                utOut_q <= 1'b0;
            else if (utOut_q && crossT2)
                utHit_q <= 1'b1;
        end
    end

    // ************************************************************
    // condition select
    // ************************************************************
    logic condMet;
    wire  stayLong = smp.valid && regionNow && !stateChg && !stayFired_q
                     && width > cfg_q.time1;
    always_comb begin
        unique case (cfg_q.ttype)
            TRG_EDGE:    condMet = (cfg_q.dir == 2'h0) ? riseX : fallX;
            TRG_ADVEDGE: condMet = (cfg_q.dir == 2'h2) ? (hRise || hFall)
                                 : ((cfg_q.dir == 2'h0) ? hRise : hFall);
            TRG_WINDOW:  condMet = (cfg_q.dir == 2'h0) ? enterW :
                                   (cfg_q.dir == 2'h1) ? exitW :
                                   (enterW || exitW);
            TRG_PWIDTH:  condMet = pEnd && inPulse_q && winMatch;
            TRG_INTERV:  condMet = ivEdge && seenEdge_q && winMatch;
            TRG_WINPW:   condMet = stayLong;
            TRG_HDIST:   condMet = stayLong;
            TRG_WDIST:   condMet = stayLong;
            TRG_UNDER:   condMet = utBack && utOut_q && !utHit_q;
            default:     condMet = 1'b0;
        endcase
    end

    // continuous streaming is limited to the plain edge trigger
    wire typeOk = !cont_q || cfg_q.ttype == TRG_EDGE;

    always_ff @(posedge core_clk) begin
        if (reset || armPulse) begin
            prev_q       <= 16'h0000;
            prevOk_q     <= 1'b0;
            inPulse_q    <= 1'b0;
            seenEdge_q   <= 1'b0;
            regionPrev_q <= 1'b0;
            stayFired_q  <= 1'b0;
        end else if (clkEn && smp.valid) begin
            prev_q       <= smp.data;
            prevOk_q     <= 1'b1;
            regionPrev_q <= regionNow;
            if (pStart)
                inPulse_q <= 1'b1;
            else if (pEnd)
                inPulse_q <= 1'b0;
            if (ivEdge)
                seenEdge_q <= 1'b1;
            if (stateChg)
                stayFired_q <= 1'b0;
            else if (stayLong)
                stayFired_q <= 1'b1;
        end
    end

    // ************************************************************
    // capture mode control
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CAPT = 2'b10,
        ST_HALT = 2'b11
    } ste_state_t;

    ste_state_t st_q;
    ste_state_t st_d;
    logic [31:0] autoCnt_q;
    wire  waiting  = st_q == ST_WAIT && !stopPulse && !armPulse;
    wire  hit      = waiting && condMet && typeOk;
    wire  autoFire = waiting && mode_q == MODE_AUTO && !hit
                     && smp.valid && autoCnt_q >= autoLim_q;
    logic [31:0] trigCnt_q;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (armPulse)
                         st_d = (ste_mode_t'(trigWord[`STE_TRG_MODE_LO +: 2])
                                 == MODE_NONE) ? ST_CAPT : ST_WAIT;
            ST_WAIT: if (hit || autoFire)
                         st_d = ST_CAPT;
            ST_CAPT: if (captureDone && mode_q != MODE_NONE)
                         st_d = (mode_q == MODE_SINGLE) ? ST_HALT
                                                        : ST_WAIT;
            ST_HALT: st_d = ST_HALT;
        endcase
        if (stopPulse)
            st_d = ST_IDLE;
        else if (armPulse)
            st_d = (ste_mode_t'(trigWord[`STE_TRG_MODE_LO +: 2])
                    == MODE_NONE) ? ST_CAPT : ST_WAIT;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q       <= ST_IDLE;
            autoCnt_q  <= `STE_RST_WORD;
            trigStrobe <= 1'b0;
            forcedTrig <= 1'b0;
            trigCnt_q  <= `STE_RST_WORD;
        end else if (clkEn) begin
            st_q       <= st_d;
            trigStrobe <= hit || autoFire;
            forcedTrig <= autoFire;
            if (!waiting || hit || autoFire)
                autoCnt_q <= `STE_RST_WORD;
            else if (smp.valid)
                autoCnt_q <= autoCnt_q + `STE_ONE_CNT;
            if (hit || autoFire)
                trigCnt_q <= trigCnt_q + `STE_ONE_CNT;
        end
    end

    // captures flow in None mode from the arm write until a stop; otherwise only after a trigger
    assign captureEn  = st_q == ST_CAPT;
    assign streamMode = cont_q && st_q != ST_IDLE;
    assign statusWord = {28'h0000000, cont_q, st_q == ST_HALT,
                         st_q};
    assign countWord  = trigCnt_q;
endmodule : ste_trigger_engine

// [hdl/ste_width_cmp.sv]
// duration counter and width condition check
`timescale 1ns/1ps
`include "ste_regs.svh"
module ste_width_cmp
    import ste_pkg::*;
(
    // clocking
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // control
    input  wire logic        smpValid,
    input  wire logic        restart,
    input  wire logic        stop,
    input  wire logic [1:0]  cond,
    input  wire logic [31:0] time1,
    input  wire logic [31:0] time2,
    // result
    output logic [31:0]      width,
    output logic             match
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    wire  [31:0] endW = cnt_q + `STE_ONE_CNT;

    // durations count sample-clock periods, saturating
    assign cnt_d = restart ? `STE_ONE_CNT :
                   (&cnt_q) ? cnt_q : endW;
    assign width = cnt_q;

    // width compared once the measured interval closes
    always_comb begin
        unique case (cond)
            2'h0: match = cnt_q > time1;
            2'h1: match = cnt_q < time1;
            2'h2: match = cnt_q > time1 && cnt_q < time2;
            2'h3: match = cnt_q < time1 || cnt_q > time2;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset)
            cnt_q <= `STE_RST_WORD;
        else if (clkEn && smpValid && !stop)
            cnt_q <= cnt_d;
    end
endmodule : ste_width_cmp

// [verif/ste_sample_src.sv]
// front end model: one channel at a set level, the rest inverted
`timescale 1ns/1ps
module ste_sample_src (
    // clocking
    input wire logic        core_clk,
    input wire logic        reset,
    // bench settings
    input wire logic [1:0]  selChan,
    input wire logic [15:0] level,
    // sample stream
    output logic            smpValid,
    output logic [63:0]     smpData
);
    // unselected channels cross the other way, so a wrong pick shows
    always_ff @(posedge core_clk) begin
        smpValid <= !reset;
        for (int i = 0; i < 4; i++)
            smpData[i*16 +: 16] <= (i == selChan) ? level : ~level;
    end
endmodule : ste_sample_src

// [verif/ste_trigger_engine_sva.sv]
// concurrent checks on the trigger engine ports
`timescale 1ns/1ps
module ste_trigger_engine_sva (
    // clocking
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // stream and capture
    input wire logic smpValid,
    input wire logic trigStrobe,
    input wire logic captureEn,
    input wire logic forcedTrig,
    input wire logic streamMode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_ready; s_setup ##1 s_access |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    property p_err; pslverr |-> s_access; endproperty
    a_err: assert property (p_err) else $error("error outside access");
    property p_pulse; trigStrobe && clkEn |=> !trigStrobe; endproperty
    a_pulse: assert property (p_pulse) else $error("long strobe");
    property p_forced; forcedTrig |-> trigStrobe; endproperty
    a_forced: assert property (p_forced) else $error("lone forced");
    property p_cap; trigStrobe |-> captureEn; endproperty
    a_cap: assert property (p_cap) else $error("strobe, no capture");
    property p_cause; trigStrobe && !forcedTrig |-> $past(smpValid); endproperty
    a_cause: assert property (p_cause) else $error("no sample");
    // a frozen engine must not drift, or captures would tear
    property p_freeze;
        !clkEn |=> $stable({trigStrobe, captureEn, streamMode});
    endproperty
    a_freeze: assert property (p_freeze) else $error("moved while frozen");
    property p_rst; $past(reset) |-> !trigStrobe && !captureEn; endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
endmodule : ste_trigger_engine_sva

bind ste_trigger_engine ste_trigger_engine_sva ste_trigger_engine_sva_inst (
    .core_clk, .reset, .clkEn, .psel, .penable, .pready, .pslverr,
    .smpValid, .trigStrobe, .captureEn, .forcedTrig, .streamMode);

// [verif/tb_ste_trigger_engine.sv]
// self-checking bench for the trigger engine
`timescale 1ns/1ps
`include "ste_regs.svh"
module tb_ste_trigger_engine;
    import ste_pkg::*;
    localparam logic [15:0] LO = 16'h0000, HI = 16'h00c8, MID = 16'h0046;
    localparam logic [15:0] BIG = 16'h01f4, TOP = 16'h0190;
    localparam logic [31:0] T1 = 32'h64, T2 = 32'h32, TU = 32'h12c;
    localparam logic [31:0] NG = 32'hffff_ff9c;
    logic        core_clk = 0, reset = 1, clkEn = 1, captureDone = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, smpValid, err, f, g;
    logic        trigStrobe, captureEn, forcedTrig, streamMode;
    logic [63:0] smpData;
    logic [1:0]  selChan = 0;
    logic [15:0] level = '0, base = '0;
    int          error_cnt = 0, n_tests = 0;

    always #2 core_clk = ~core_clk;

    ste_trigger_engine ste_trigger_engine_inst (.core_clk, .reset, .clkEn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .smpValid, .smpData, .captureDone, .trigStrobe,
        .captureEn, .forcedTrig, .streamMode);
    ste_sample_src ste_sample_src_inst (.core_clk, .reset, .selChan,
        .level, .smpValid, .smpData);

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) begin
            error_cnt++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    function automatic logic [31:0] tw(input logic [3:0] ty,
        input logic [1:0] mo, input int di, co, hy = 0);
        return {19'h0, hy[0], co[1:0], di[1:0], selChan, mo, ty};
    endfunction : tw

    // settings only while stopped, then one arm write
    task automatic setup(input logic [31:0] trig, t1, t2,
                         input logic [15:0] lo, input logic [31:0] ctl);
        base = lo;
        level <= lo;
        apb(1'b1, `STE_A_CTRL, 32'h2);
        apb(1'b1, `STE_A_THR1, t1);
        apb(1'b1, `STE_A_THR2, t2);
        apb(1'b1, `STE_A_TIME1, 32'h5);
        apb(1'b1, `STE_A_TIME2, 32'h20);
        apb(1'b1, `STE_A_TRIG, trig);
        apb(1'b1, `STE_A_CTRL, ctl);
        repeat (4) @(posedge core_clk);
    endtask : setup

    // hold v w+1 samples, then base; f strobe, g forced
    task automatic watch(input logic [15:0] v, input int w);
        level <= v;
        f = 0;
        g = 0;
        for (int n = 0; n < 80; n++) begin
            @(posedge core_clk);
            if (n == w) level <= base;
            if (trigStrobe === 1'b1) f = 1;
            if (forcedTrig === 1'b1) g = 1;
            captureDone <= trigStrobe;
        end
    endtask : watch

    task automatic tc(input logic [31:0] trig, t1, t2,
                      input logic [15:0] lo, hi, input int w, e);
        setup(trig, t1, t2, lo, 32'h1);
        watch(hi, w);
        chk({31'h0, f}, {31'h0, e[0]});
    endtask : tc

    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, `STE_A_AUTO, 32'h0);
        chk(rd, `STE_RST_AUTO);
        apb(1'b0, 12'h030, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        for (int c = 0; c < 4; c++) begin
            selChan <= c[1:0];
            @(posedge core_clk);
            tc(tw(TRG_EDGE, MODE_REPEAT, 0, 0), T1, T2, LO, HI, 999, 1);
        end
        tc(tw(TRG_EDGE, MODE_REPEAT, 1, 0), T1, T2, LO, HI, 999, 0);
        tc(tw(TRG_EDGE, MODE_REPEAT, 1, 0), T1, T2, HI, LO, 999, 1);
        tc(tw(TRG_ADVEDGE, MODE_REPEAT, 2, 0), T1, T2, HI, LO, 999, 1);
        tc(tw(TRG_ADVEDGE, MODE_REPEAT, 0, 0, 1), T1, T2, LO, HI, 999, 1);
        tc(tw(TRG_ADVEDGE, MODE_REPEAT, 0, 0, 1), T1, T2, MID, HI, 999, 0);
        for (int d = 0; d < 3; d++)
            tc(tw(TRG_WINDOW, MODE_REPEAT, d, 0), T1, NG, BIG, LO, 999, d != 1);
        for (int k = 0; k < 4; k++)
            tc(tw(TRG_PWIDTH, MODE_REPEAT, 0, k), T1, T2, LO, HI, 12, k[0] == 0);
        tc(tw(TRG_WINPW, MODE_REPEAT, 0, 0), T1, NG, BIG, LO, 999, 1);
        tc(tw(TRG_HDIST, MODE_REPEAT, 0, 0), T1, T2, LO, HI, 999, 1);
        tc(tw(TRG_HDIST, MODE_REPEAT, 0, 0), T1, T2, LO, HI, 1, 0);
        tc(tw(TRG_WDIST, MODE_REPEAT, 0, 0), T1, NG, BIG, LO, 999, 1);
        tc(tw(TRG_UNDER, MODE_REPEAT, 0, 0), T1, TU, LO, HI, 3, 1);
        tc(tw(TRG_UNDER, MODE_REPEAT, 0, 0), T1, TU, LO, TOP, 3, 0);
        tc(tw(TRG_INTERV, MODE_REPEAT, 0, 0), T1, T2, LO, HI, 3, 0);
        watch(HI, 3);
        chk({31'h0, f}, 32'h1);
        setup(tw(TRG_EDGE, MODE_NONE, 0, 0), T1, T2, LO, 32'h1);
        clkEn <= 1'b0;
        repeat (3) @(posedge core_clk);
        clkEn <= 1'b1;
        chk({31'h0, captureEn}, 32'h1);
        apb(1'b1, `STE_A_CTRL, 32'h2);
        apb(1'b1, `STE_A_AUTO, 32'h14);
        setup(tw(TRG_EDGE, MODE_AUTO, 0, 0), T1, T2, LO, 32'h1);
        watch(LO, 999);
        chk({31'h0, g}, 32'h1);
        tc(tw(TRG_EDGE, MODE_SINGLE, 0, 0), T1, T2, LO, HI, 5, 1);
        watch(HI, 999);
        chk({30'h0, f, captureEn}, 32'h0);
        setup(tw(TRG_EDGE, MODE_REPEAT, 0, 0), T1, T2, LO, 32'h5);
        chk({31'h0, streamMode}, 32'h1);
        watch(HI, 999);
        chk({31'h0, f}, 32'h1);
        end_of_test();
    end
endmodule : tb_ste_trigger_engine
